// File: verilog/evlog_pkg.sv
/*
 * Constants and carriers of the event log handshake window.
 * Assumes the window base is already subtracted by the command decoder.
 */
`default_nettype none

package evlog_pkg;

    // ****************************************************************
    // Window layout
    // ****************************************************************
    localparam int unsigned NUM_SLOTS        = 3;
    localparam int unsigned SLOT_WORDS       = 8;
    localparam int unsigned WINDOW_WORDS     = 2 + NUM_SLOTS * SLOT_WORDS;
    localparam logic [15:0] OFF_PENDING      = 16'h0000;
    localparam logic [15:0] OFF_HANDSHAKE    = 16'h0001;
    localparam logic [15:0] OFF_FIRST_SLOT   = 16'h0002;

    // ****************************************************************
    // Handshake field positions
    // ****************************************************************
    localparam int unsigned HS_TAG_LSB       = 0;
    localparam int unsigned HS_TAG_MSB       = 7;
    localparam int unsigned HS_NUM_LSB       = 8;
    localparam int unsigned HS_NUM_MSB       = 9;
    localparam int unsigned HS_SCAN_BIT      = 14;
    localparam int unsigned HS_ERASE_BIT     = 15;
    localparam int unsigned HS_OVF_BIT       = 15;
    localparam logic [7:0]  TAG_RESET        = 8'h00;
    localparam logic [7:0]  TAG_FIRST        = 8'h01;
    localparam logic [7:0]  TAG_LAST         = 8'hFF;

    // ****************************************************************
    // Slot contents
    // ****************************************************************
    localparam int unsigned TYPE_LSB         = 0;
    localparam logic [7:0]  TYPE_EMPTY       = 8'hFF;

    // ****************************************************************
    // Answers
    // ****************************************************************
    localparam logic [7:0]  EXC_NONE         = 8'h00;
    localparam logic [7:0]  EXC_BAD_ADDRESS  = 8'h02;
    localparam logic [7:0]  EXC_BAD_VALUE    = 8'h03;

    typedef logic [SLOT_WORDS*16-1:0] entry_t;

    typedef struct packed {
        logic        write;   // 1 = write
        logic [15:0] addr;    // first window index
        logic [7:0]  count;   // number of registers
        logic [15:0] wdata;   // write value
    } req_t;

    typedef struct packed {
        logic        last;    // final word
        logic [7:0]  exc;     // exception code, zero if good
        logic [15:0] data;    // word or write echo
    } rsp_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_FILL = 3'b100
    } state_t;

endpackage

`default_nettype wire

// File: verilog/event_log_handshake_window.sv
/*
 * Event log handshake window: entry FIFO, event ring, slots and answer stream.
 * Assumes requests and events come from clk logic, one request at a time.
 */
// Notes on behaviour
// - Window: pending count, handshake, three read-only eight-word slots.
// - Legal: handshake alone, handshake plus first one to three slots, pending count alone or before any of these.
// - Other accesses, partial slot reads too, answer exception 02.
// - Pending count is ring plus slot entries, zero to depth plus three.
// - Unacknowledged occupied slots count as pending beside the ring depth.
// - Each presentation bumps the tag, 1 to 255, then back to 1.
// - Tag is zero only before the first entry after reset.
// - Without a new presentation the tag stays, however often read.
// - Handshake bits 9:8 read the valid slot count.
// - Empty slots carry the all-ones type byte.
// - Handshake read bits 14:10 are zero.
// - Bit 15 flags overflow; acknowledge clears it unless overflow recurred.
// - Slots stay unchanged until the matching tag is written back or bit 15 erases them.
// - After an acknowledge only the last read tag or zero is accepted.
// - A nonzero tag unlike the last read one answers exception 03.
// - Tag zero is always accepted and only runs the command bits.
// - Consumed zero keeps the slots, tops up empty ones, bumps the tag.
// - Smaller consumed count deletes that many, shifts, refills, bumps.
// - Equal consumed count deletes all; further entries are presented with a bump.
// - A consumed count above the valid count acts as equal.
// - Written bits 13:10 are ignored.
// - Bit 14 starts one rescan, ignored while one runs.
// - Bit 15 erases ring and slot entries, not those still in the entry FIFO; the tag is untouched.
// - Both command bits: erase first, then rescan.
// - The ring overwrites its oldest entry when full.
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Entry FIFO
// ****************************************************************
module entry_fifo #(
    parameter int unsigned WIDTH = 128,
    parameter int unsigned DEPTH = 4
) (
    input  wire logic             clk,        // system clock
    input  wire logic             reset,      // asynchronous, active high
    input  wire logic             in_valid,   // source offers a word
    output var  logic             in_ready,   // room for a word
    input  wire logic [WIDTH-1:0] in_data,    // offered word
    output var  logic             out_valid,  // a word is held
    input  wire logic             out_ready,  // sink takes the word
    output var  logic [WIDTH-1:0] out_data    // oldest word
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial
    begin
        if (DEPTH < 2 || WIDTH < 1)
            $error("entry_fifo needs a depth of at least two");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q;
    logic [PW-1:0]    rd_q;
    logic [PW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];

    function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
        wrap_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge clk)
    begin
        if (push)
            mem_q[wr_q] <= in_data;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= wrap_inc(wr_q);
            if (pop)
                rd_q <= wrap_inc(rd_q);
            if (push && !pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop && !push)
                cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule // entry_fifo

// ****************************************************************
// Handshake window
// ****************************************************************
module event_log_handshake_window
    import evlog_pkg::*;
#(
    parameter int unsigned RING_DEPTH = 16,  // ring entries
    parameter int unsigned FIFO_DEPTH = 4    // entry FIFO depth
) (
    input  wire logic   clk,                  // system clock
    input  wire logic   reset,                // asynchronous, active high
    input  wire logic   req_valid,            // register request offered
    input  wire req_t   req,                  // request fields
    output var  logic   req_ready,            // request taken
    output var  logic   rsp_valid,            // one answer word this cycle
    output var  rsp_t   rsp,                  // answer word
    input  wire logic   ev_valid,             // new log entry offered
    input  wire entry_t ev_data,              // log entry
    output var  logic   ev_ready,             // entry FIFO has room
    output var  logic   full_rescan_request,  // rescan start pulse
    input  wire logic   full_rescan_busy      // a full rescan is running
);
    localparam int unsigned RW = $clog2(RING_DEPTH + 1);
    localparam int unsigned PW = (RING_DEPTH > 1) ? $clog2(RING_DEPTH) : 1;

    initial
    begin
        if (RING_DEPTH < 1 || RING_DEPTH > 65532 || FIFO_DEPTH < 2)
            $error("event_log_handshake_window: unsupported depth");
    end

    state_t      st_q;
    state_t      st_d;
    entry_t      ring_q [RING_DEPTH];
    logic [PW-1:0] head_q;
    logic [RW-1:0] ring_cnt_q;
    entry_t      slot_q [NUM_SLOTS];
    logic [1:0]  slot_cnt_q;
    logic [7:0]  tag_q;
    logic [7:0]  tag_read_q;
    logic [1:0]  read_valid_q;
    logic        acked_q;
    logic        ovf_q;
    logic        ovf_new_q;
    logic        scan_q;
    logic        ready_q;
    entry_t      snap_slot_q [NUM_SLOTS];
    logic [15:0] snap_pend_q;
    logic [15:0] snap_hs_q;
    logic [1:0]  snap_valid_q;
    logic [15:0] cur_q;
    logic [7:0]  rem_q;
    logic        rsp_valid_q;
    rsp_t        rsp_q;

    logic        fifo_valid;
    entry_t      fifo_data;
    logic        take;
    logic        legal;
    logic        do_read;
    logic        hs_read;
    logic        is_wr;
    logic        wr_reject;
    logic        do_ack;
    logic        do_erase;
    logic        do_scan;
    logic [1:0]  consumed;
    logic        push;
    logic        pop;
    logic        fill_done;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic access_ok(input req_t r);
        if (r.write)
            access_ok = (r.addr == OFF_HANDSHAKE) && (r.count == 8'h01);
        else if (r.addr == OFF_HANDSHAKE)
            access_ok = r.count inside {8'h01, 8'h09, 8'h11, 8'h19};
        else
            access_ok = (r.addr == OFF_PENDING) && (r.count inside {8'h01, 8'h02, 8'h0A, 8'h12, 8'h1A});
    endfunction

    function automatic logic [7:0] tag_next(input logic [7:0] t);
        tag_next = (t == TAG_LAST) ? TAG_FIRST : t + 1'b1;
    endfunction

    function automatic logic [PW-1:0] ring_idx(input logic [PW-1:0] base, input logic [RW-1:0] off);
        logic [RW:0] s;
        s = {1'b0, RW'(base)} + {1'b0, off};
        if (s >= (RW+1)'(RING_DEPTH))
            s = s - (RW+1)'(RING_DEPTH);
        ring_idx = s[PW-1:0];
    endfunction

    function automatic logic [15:0] window_word(input logic [15:0] a);
        logic [15:0] rel;
        logic [1:0]  idx;
        logic [2:0]  w;
        rel = a - OFF_FIRST_SLOT;
        idx = rel[4:3];
        w   = rel[2:0];
        if (a == OFF_PENDING)
            window_word = snap_pend_q;
        else if (a == OFF_HANDSHAKE)
            window_word = snap_hs_q;
        else if (idx >= snap_valid_q)
            window_word = (w == 3'd0) ? (16'(TYPE_EMPTY) << TYPE_LSB) : 16'h0000;
        else
            window_word = snap_slot_q[idx][w*16 +: 16];
    endfunction

    entry_fifo #(
        .WIDTH ($bits(entry_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (ev_valid),
        .in_ready  (ev_ready),
        .in_data   (ev_data),
        .out_valid (fifo_valid),
        .out_ready (push),
        .out_data  (fifo_data)
    );

    // ****************************************************************
    // Request decode
    // ****************************************************************
    always_comb
    begin
        take      = req_valid && ready_q;
        legal     = access_ok(req);
        do_read   = take && legal && !req.write;
        hs_read   = do_read && (req.addr == OFF_HANDSHAKE || req.count > 8'h01);
        is_wr     = take && legal && req.write;
        wr_reject = is_wr && (req.wdata[HS_TAG_MSB:HS_TAG_LSB] != TAG_RESET)
                          && (req.wdata[HS_TAG_MSB:HS_TAG_LSB] != tag_read_q);
        do_ack    = is_wr && !wr_reject && !acked_q
                          && (req.wdata[HS_TAG_MSB:HS_TAG_LSB] != TAG_RESET);
        do_erase  = is_wr && !wr_reject && req.wdata[HS_ERASE_BIT];
        do_scan   = is_wr && !wr_reject && req.wdata[HS_SCAN_BIT]
                          && !full_rescan_busy && !scan_q;
        consumed  = req.wdata[HS_NUM_MSB:HS_NUM_LSB];
        if (consumed > read_valid_q)
            consumed = read_valid_q;
        if (consumed > slot_cnt_q)
            consumed = slot_cnt_q;
        push      = fifo_valid && (st_q == ST_IDLE) && !take;
        pop       = (st_q == ST_FILL) && (slot_cnt_q != 2'd3) && (ring_cnt_q != '0);
        fill_done = (st_q == ST_FILL) && !pop;
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE:
            begin
                if (do_read)
                    st_d = ST_READ;
                else if (do_ack && !do_erase)
                    st_d = ST_FILL;
                else if (!take && slot_cnt_q == 2'd0 && ring_cnt_q != '0)
                    st_d = ST_FILL;
            end
            ST_READ:
            begin
                if (rem_q == 8'h01)
                    st_d = ST_IDLE;
            end
            ST_FILL:
            begin
                if (fill_done)
                    st_d = ST_IDLE;
            end
            default:
                st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            st_q    <= ST_IDLE;
            ready_q <= 1'b0;
        end
        else
        begin
            st_q    <= st_d;
            ready_q <= (st_d == ST_IDLE);
        end
    end

    // ****************************************************************
    // Event ring
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (push)
            ring_q[ring_idx(head_q, (ring_cnt_q == RW'(RING_DEPTH)) ? '0 : ring_cnt_q)] <= fifo_data;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            head_q     <= '0;
            ring_cnt_q <= '0;
        end
        else if (do_erase)
        begin
            head_q     <= '0;
            ring_cnt_q <= '0;
        end
        else if (push && ring_cnt_q == RW'(RING_DEPTH))
            head_q <= ring_idx(head_q, RW'(1));
        else if (push)
            ring_cnt_q <= ring_cnt_q + 1'b1;
        else if (pop)
        begin
            head_q     <= ring_idx(head_q, RW'(1));
            ring_cnt_q <= ring_cnt_q - 1'b1;
        end
    end

    // ****************************************************************
    // Presentation slots
    // ****************************************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            slot_cnt_q <= 2'd0;
            for (int i = 0; i < NUM_SLOTS; i++)
                slot_q[i] <= '0;
        end
        else if (do_erase)
            slot_cnt_q <= 2'd0;
        else if (do_ack)
        begin
            for (int i = 0; i < NUM_SLOTS; i++)
                if (i + consumed < NUM_SLOTS)
                    slot_q[i] <= slot_q[i + consumed];
            slot_cnt_q <= slot_cnt_q - consumed;
        end
        else if (pop)
        begin
            slot_q[slot_cnt_q] <= ring_q[head_q];
            slot_cnt_q         <= slot_cnt_q + 1'b1;
        end
    end

    // ****************************************************************
    // Tag, acknowledge and overflow tracking
    // ****************************************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            tag_q <= TAG_RESET;
        else if (fill_done && slot_cnt_q != 2'd0)
            tag_q <= tag_next(tag_q);
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            tag_read_q   <= TAG_RESET;
            read_valid_q <= 2'd0;
            acked_q      <= 1'b0;
        end
        else if (hs_read)
        begin
            tag_read_q   <= tag_q;
            read_valid_q <= slot_cnt_q;
            acked_q      <= 1'b0;
        end
        else if (do_ack || do_erase)
            acked_q <= 1'b1;
    end

    // Overflow and acknowledge never meet: the ring is not pushed on a take.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ovf_q     <= 1'b0;
            ovf_new_q <= 1'b0;
        end
        else if (do_erase)
        begin
            ovf_q     <= 1'b0;
            ovf_new_q <= 1'b0;
        end
        else if (push && ring_cnt_q == RW'(RING_DEPTH))
        begin
            ovf_q     <= 1'b1;
            ovf_new_q <= 1'b1;
        end
        else if (do_ack)
            ovf_q <= ovf_new_q;
        else if (hs_read)
            ovf_new_q <= 1'b0;
    end

    // Erase acts at the take edge, so a rescan on this pulse logs into an empty ring.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            scan_q <= 1'b0;
        else
            scan_q <= do_scan;
    end

    // ****************************************************************
    // Answer stream
    // ****************************************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            snap_pend_q  <= 16'h0000;
            snap_hs_q    <= 16'h0000;
            snap_valid_q <= 2'd0;
            for (int i = 0; i < NUM_SLOTS; i++)
                snap_slot_q[i] <= '0;
        end
        else if (do_read)
        begin
            snap_pend_q  <= 16'(ring_cnt_q) + 16'(slot_cnt_q);
            snap_hs_q    <= {ovf_q, 5'b00000, slot_cnt_q, tag_q};
            snap_valid_q <= slot_cnt_q;
            for (int i = 0; i < NUM_SLOTS; i++)
                snap_slot_q[i] <= slot_q[i];
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cur_q       <= 16'h0000;
            rem_q       <= 8'h00;
            rsp_valid_q <= 1'b0;
            rsp_q       <= '0;
        end
        else if (take && !legal)
        begin
            rsp_valid_q <= 1'b1;
            rsp_q       <= '{last: 1'b1, exc: EXC_BAD_ADDRESS, data: 16'h0000};
        end
        else if (is_wr)
        begin
            rsp_valid_q <= 1'b1;
            rsp_q       <= '{last: 1'b1, exc: wr_reject ? EXC_BAD_VALUE : EXC_NONE,
                             data: req.wdata};
        end
        else if (do_read)
        begin
            cur_q       <= req.addr;
            rem_q       <= req.count;
            rsp_valid_q <= 1'b0;
        end
        else if (st_q == ST_READ)
        begin
            rsp_valid_q <= 1'b1;
            rsp_q       <= '{last: (rem_q == 8'h01), exc: EXC_NONE, data: window_word(cur_q)};
            cur_q       <= cur_q + 16'h0001;
            rem_q       <= rem_q - 8'h01;
        end
        else
            rsp_valid_q <= 1'b0;
    end

    assign req_ready           = ready_q;
    assign rsp_valid           = rsp_valid_q;
    assign rsp                 = rsp_q;
    assign full_rescan_request = scan_q;

endmodule // event_log_handshake_window

`default_nettype wire

// File: verification/evlog_chk.sv
/* Checker for the event log handshake window ports.
   Assumes it is bound to the design top and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
// ****************
// Port checker
// ****************
module evlog_chk
    import evlog_pkg::*;
(
    input wire logic clk,                  // clock
    input wire logic reset,                // reset
    input wire logic req_valid,            // request offered
    input wire req_t req,                  // request
    input wire logic req_ready,            // request taken
    input wire logic rsp_valid,            // answer word
    input wire rsp_t rsp,                  // answer
    input wire logic full_rescan_request,  // rescan start
    input wire logic full_rescan_busy      // rescan running
);
    logic       take, hs_rd, wr1;
    logic [2:0] hs_q;
    logic [7:0] tag_q;
    assign take  = req_valid && req_ready;
    assign hs_rd = take && !req.write && req.addr == OFF_HANDSHAKE && req.count inside {8'h01, 8'h09, 8'h11, 8'h19};
    assign wr1   = take && req.write && req.addr == OFF_HANDSHAKE && req.count == 8'h01;
    // Tag last shown to the master, from a handshake or pending-count read.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            hs_q  <= 3'h0;
            tag_q <= 8'h00;
        end
        else
        begin
            hs_q <= {hs_q[1], hs_q[0] | hs_rd,
                     take && !req.write && req.addr == OFF_PENDING && req.count inside {8'h02, 8'h0A, 8'h12, 8'h1A}};
            if (hs_q[2] && rsp_valid)
                tag_q <= rsp.data[7:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_hs_reserved: assert property (hs_rd |-> ##2 rsp_valid && rsp.data[14:10] == 5'h00)
        else $error("Handshake read returned set reserved bits.");
    a_bad_addr: assert property (take && req.addr > OFF_HANDSHAKE |-> ##1 rsp_valid && rsp.last && rsp.exc == EXC_BAD_ADDRESS)
        else $error("Slot access without handshake not refused.");
    a_zero_tag: assert property (wr1 && req.wdata[7:0] == 8'h00 |-> ##1 rsp_valid && rsp.exc == EXC_NONE)
        else $error("Write with zero tag refused.");
    a_wrong_tag: assert property (wr1 && req.wdata[7:0] != 8'h00 && req.wdata[7:0] != tag_q |-> ##1 rsp.exc == EXC_BAD_VALUE)
        else $error("Wrong tag not refused.");
    a_scan_start: assert property (wr1 && req.wdata[7:0] == 8'h00 && req.wdata[HS_SCAN_BIT] && !full_rescan_busy
        && !full_rescan_request |-> ##1 full_rescan_request)
        else $error("Rescan command gave no start pulse.");
    a_scan_ignored: assert property (full_rescan_request |-> !$past(full_rescan_busy))
        else $error("Rescan started while one was running.");
    a_read_stream: assert property (hs_rd && req.count == 8'h19 |-> ##2 (rsp_valid && !rsp.last) [*8])
        else $error("Window read stream broken.");
    a_read_stall: assert property (hs_rd |=> !req_ready)
        else $error("Request accepted during a read stream.");
endmodule // evlog_chk
`default_nettype wire

// File: verification/rescan_model.sv
/* Rescan model: logs a burst of entries after each rescan start.
   Assumes the one-cycle start pulse on the shared clock. */
`timescale 1ns/10ps
`default_nettype none
// ****************
// Rescan model
// ****************
module rescan_model
    import evlog_pkg::*;
#(
    parameter int unsigned N_LOG = 5  // entries per rescan
) (
    input  wire logic   clk,                  // clock
    input  wire logic   reset,                // reset
    input  wire logic   full_rescan_request,  // start pulse
    output var  logic   full_rescan_busy,     // rescan running
    output var  logic   ev_valid,             // entry offered
    output var  entry_t ev_data,              // entry
    input  wire logic   ev_ready              // entry room
);
    logic [7:0] left_q, seq_q;
    // Idle data is all ones so that a stray capture shows as an empty type.
    assign full_rescan_busy = left_q != 8'h00;
    assign ev_valid         = full_rescan_busy;
    assign ev_data          = ev_valid ? entry_t'(seq_q) : '1;
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            left_q <= 8'h00;
            seq_q  <= 8'h01;
        end
        else if (full_rescan_request && !full_rescan_busy)
            left_q <= 8'(N_LOG);
        else if (ev_valid && ev_ready)
        begin
            left_q <= left_q - 8'h01;
            seq_q  <= seq_q + 8'h01;
        end
    end
endmodule // rescan_model
`default_nettype wire

// File: verification/tb.sv
/* Testbench: register requests with expected answers.
   Assumes the rescan model supplies the log entries. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("Error t=%0t got %0h exp %0h", $time, g, e); end end
// ****************
// Top
// ****************
module tb import evlog_pkg::*;;
    logic        clk = 1'b0, reset = 1'b1, req_valid = 1'b0, req_ready, rsp_valid, ev_valid, ev_ready;
    logic        full_rescan_request, full_rescan_busy;
    req_t        req = '0;
    rsp_t        rsp;
    entry_t      ev_data;
    int          err_count = 0, n_compared = 0;
    logic [15:0] q[$];
    logic [7:0]  exc, tg;
    logic [24:0] bad [5] = '{25'h0000003, 25'h0000102, 25'h0000208, 25'h000011A, 25'h1000001};
    always #5 clk = ~clk;
    event_log_handshake_window #(.RING_DEPTH(8), .FIFO_DEPTH(4)) event_log_handshake_window_inst (.clk(clk),
        .reset(reset), .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
        .ev_valid(ev_valid), .ev_data(ev_data), .ev_ready(ev_ready), .full_rescan_request(full_rescan_request),
        .full_rescan_busy(full_rescan_busy));
    rescan_model #(.N_LOG(5)) rescan_model_inst (.clk(clk), .reset(reset), .full_rescan_request(full_rescan_request),
        .full_rescan_busy(full_rescan_busy), .ev_valid(ev_valid), .ev_data(ev_data), .ev_ready(ev_ready));
    task automatic give_verdict();
        $display("Compared %0d, errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] n, input logic [15:0] d = 16'h0000);
        int i = 0;
        q = {};
        @(posedge clk);
        req_valid <= 1'b1;
        req       <= '{w, a, n, d};
        do @(negedge clk); while (!req_ready && ++i < 50);
        @(posedge clk);
        req_valid <= 1'b0;
        for (; i < 110; i++)
        begin
            @(negedge clk);
            if (rsp_valid)
            begin
                q.push_back(rsp.data);
                if (q.size() == 1)
                    exc = rsp.exc;
                if (rsp.last)
                    return;
            end
        end
        err_count++;
        give_verdict();
    endtask
    task automatic wait_pending(input logic [15:0] n);
        for (int i = 0; i < 40; i++)
        begin
            xfer(1'b0, 16'h0000, 8'h01);
            if (q[0] === n)
                return;
        end
        err_count++;
        give_verdict();
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        xfer(1'b0, 16'h0001, 8'h01);
        `CHK(q[0], 16'h0000)
        foreach (bad[k])
        begin
            xfer(bad[k][24], bad[k][23:8], bad[k][7:0]);
            `CHK(exc, EXC_BAD_ADDRESS)
        end
        xfer(1'b1, 16'h0001, 8'h01, 16'h4000);
        `CHK(exc, EXC_NONE)
        wait_pending(16'h0005);
        xfer(1'b0, 16'h0001, 8'h01);
        tg = q[0][7:0];
        `CHK(tg != 8'h00, 1'b1)
        xfer(1'b1, 16'h0001, 8'h01, {8'h00, tg});
        tg = tg + 8'h01;
        repeat (2)
        begin
            xfer(1'b0, 16'h0001, 8'h19);
            `CHK(q[0], {8'h03, tg})
            `CHK({q[1], q[9], q[17]}, 48'h000100020003)
        end
        xfer(1'b1, 16'h0001, 8'h01, {8'h00, tg + 8'h01});
        `CHK(exc, EXC_BAD_VALUE)
        xfer(1'b1, 16'h0001, 8'h01, {8'h01, tg});
        tg = tg + 8'h01;
        xfer(1'b0, 16'h0000, 8'h1A);
        `CHK({q[0], q[1]}, {16'h0004, 8'h03, tg})
        `CHK({q[2], q[18]}, 32'h00020004)
        xfer(1'b1, 16'h0001, 8'h01, {8'h03, tg});
        tg = tg + 8'h01;
        xfer(1'b0, 16'h0001, 8'h19);
        `CHK({q[0], q[1], q[9]}, {8'h01, tg, 32'h000500FF})
        xfer(1'b1, 16'h0001, 8'h01, {8'h03, tg});
        xfer(1'b1, 16'h0001, 8'h01, {8'h03, tg});
        `CHK(exc, EXC_NONE)
        xfer(1'b0, 16'h0000, 8'h1A);
        `CHK({q[0], q[1], q[18]}, {16'h0000, 8'h00, tg, 16'h00FF})
        xfer(1'b1, 16'h0001, 8'h01, 16'hC000);
        xfer(1'b1, 16'h0001, 8'h01, 16'h4000);
        wait_pending(16'h0005);
        xfer(1'b0, 16'h0001, 8'h01);
        `CHK(q[0][7:0], tg + 8'h01)
        give_verdict();
    end
endmodule // tb
bind event_log_handshake_window evlog_chk evlog_chk_inst (.clk(clk), .reset(reset), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .full_rescan_request(full_rescan_request), .full_rescan_busy(full_rescan_busy));
`default_nettype wire
